// File: design/edge_event_line_controller.sv
`include "edge_event_params.svh"
module edge_event_line_controller #(
  parameter int NUM_LINES = `EEL_NUM_LINES,
  parameter int NUM_EXT   = `EEL_NUM_EXT,
  parameter int NUM_PINS  = `EEL_NUM_PINS
) (
  input  wire logic                  CLK,
  input  wire logic                  RST,
  input  wire logic [NUM_PINS-1:0]   PIN_IN,
  input  wire logic [NUM_LINES-1:0]  INT_SRC_IN,
  input  wire logic [5:0]            ADDR,
  input  wire logic [31:0]           WDATA,
  input  wire logic                  WR,
  input  wire logic                  RD,
  output logic      [31:0]           RDATA,
  output logic      [NUM_LINES-1:0]  IRQ_REQ,
  output logic      [NUM_LINES-1:0]  EVT_PULSE,
  output logic                       WAKEUP,
  output logic                       IRQ
);
  localparam int SEL_W = `EEL_SEL_W;

  initial begin
    if (NUM_LINES != 32) $error("register layout serves 32 lines only");
    if (NUM_EXT > NUM_LINES || NUM_EXT > 16) $error("too many external lines");
  end

  edge_event_pkg::reg_req_t  req;
  edge_event_pkg::trig_cfg_t trig_ff;
  logic [31:0]            irq_mask_ff;
  logic [31:0]            evt_mask_ff;
  logic [31:0]            wake_en_ff;
  logic [31:0]            pend_ff;
  logic [31:0]            swtrig_ff;
  logic [NUM_EXT*SEL_W-1:0] sel_ff;
  logic [NUM_EXT-1:0]     ext_lines;
  logic [NUM_LINES-1:0]   line_raw;
  logic [NUM_LINES-1:0]   rise_seen;
  logic [NUM_LINES-1:0]   fall_seen;
  logic [NUM_LINES-1:0]   rise_d_ff;
  logic [NUM_LINES-1:0]   fall_d_ff;
  logic [NUM_LINES-1:0]   ack_ff;
  logic [NUM_LINES-1:0]   hit;
  logic [31:0]            pend_clr;
  logic [31:0]            sw_set;
  logic                   wr_irq_mask;
  logic                   wr_evt_mask;
  logic                   wr_rise;
  logic                   wr_fall;
  logic                   wr_swtrig;
  logic                   wr_pend;
  logic                   wr_wake;
  logic [NUM_EXT-1:0]     wr_sel;
  logic [NUM_LINES-1:0]   rise_new;
  logic [NUM_LINES-1:0]   fall_new;
  logic [NUM_LINES-1:0]   ev_now;
  logic                   wake_hit;
  logic                   irq_any;
  logic [31:0]            sel_rd;
  logic [31:0]            rd_mux;
  // reset word, loaded whole into the mask, trigger and wake registers, indexed per line by the g_pend loop
  localparam logic [31:0] RST_WORD = `EEL_RST_WORD;

  assign req = '{addr: ADDR, wdata: WDATA, wr: WR, rd: RD};

  pin_source_mux #(
    .NUM_PINS (NUM_PINS),
    .NUM_EXT  (NUM_EXT),
    .SEL_W    (SEL_W)
  ) u_mux (
    .clk   (CLK),
    .rst   (RST),
    .pins  (PIN_IN),
    .sel   (sel_ff),
    .lines (ext_lines)
  );

  // low lines come from the pin mux, the rest from on-chip sources
  assign line_raw = {INT_SRC_IN[NUM_LINES-1:NUM_EXT], ext_lines};

  genvar g;
  for (g = 0; g < NUM_LINES; g++) begin : g_line
    pulse_catcher u_catch (
      .clk       (CLK),
      .rst       (RST),
      .line_in   (line_raw[g]),
      .ack       (ack_ff[g]),
      .rise_seen (rise_seen[g]),
      .fall_seen (fall_seen[g])
    );
    // one hit per new latched edge whose trigger bit (trig_ff.rise or trig_ff.fall) is set; ack clears the latch after it was seen
    assign hit[g] = (rise_seen[g] & ~rise_d_ff[g] & trig_ff.rise[g]) |
                    (fall_seen[g] & ~fall_d_ff[g] & trig_ff.fall[g]);
  end

  // a latched edge counts once, on the cycle its synchronised flag rises
  assign rise_new = rise_seen & ~rise_d_ff;
  assign fall_new = fall_seen & ~fall_d_ff;
  assign ev_now   = hit | sw_set;

  // edge history for the new-edge detect
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      rise_d_ff <= '0;
    end else begin
      rise_d_ff <= rise_seen;
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      fall_d_ff <= '0;
    end else begin
      fall_d_ff <= fall_seen;
    end
  end

  // clearing the latch one cycle after use re-arms it for the next edge
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      ack_ff <= '0;
    end else begin
      ack_ff <= rise_new | fall_new;
    end
  end

  // write decode, one strobe per register and one per select field
  assign wr_irq_mask = req.wr && (req.addr == `EEL_OFF_IMR);
  assign wr_evt_mask = req.wr && (req.addr == `EEL_OFF_EMR);
  assign wr_rise     = req.wr && (req.addr == `EEL_OFF_RTSR);
  assign wr_fall     = req.wr && (req.addr == `EEL_OFF_FTSR);
  assign wr_swtrig   = req.wr && (req.addr == `EEL_OFF_SWIER);
  assign wr_pend     = req.wr && (req.addr == `EEL_OFF_PR);
  assign wr_wake     = req.wr && (req.addr == `EEL_OFF_WKEN);
  // four select fields share one word
  for (g = 0; g < NUM_EXT; g++) begin : g_sel_dec
    assign wr_sel[g] = req.wr &&
                       (req.addr == `EEL_OFF_SEL0 + 6'(4 * (g / `EEL_SEL_PER_WORD)));
  end

  // interrupt and event masks, one bit per line
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      irq_mask_ff <= RST_WORD;
    end else if (wr_irq_mask) begin
      irq_mask_ff <= req.wdata;
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      evt_mask_ff <= RST_WORD;
    end else if (wr_evt_mask) begin
      evt_mask_ff <= req.wdata;
    end
  end

  // trigger edge selection
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      trig_ff <= '{rise: RST_WORD, fall: RST_WORD};
    end else begin
      if (wr_rise) begin
        trig_ff.rise <= req.wdata;
      end
      if (wr_fall) begin
        trig_ff.fall <= req.wdata;
      end
    end
  end

  // wake enable, one bit per line
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      wake_en_ff <= RST_WORD;
    end else if (wr_wake) begin
      wake_en_ff <= req.wdata;
    end
  end

  // one pin select field per external line, four fields to a word
  for (g = 0; g < NUM_EXT; g++) begin : g_sel
    always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
        sel_ff[g*SEL_W +: SEL_W] <= '0;
      end else if (wr_sel[g]) begin
        sel_ff[g*SEL_W +: SEL_W] <=
          req.wdata[(g % `EEL_SEL_PER_WORD) * `EEL_SEL_FIELD_W +: SEL_W];
      end
    end
  end

  // write-one-to-set and write-one-to-clear words
  assign sw_set   = wr_swtrig ? req.wdata : 32'h0;
  assign pend_clr = wr_pend ? req.wdata : 32'h0;

  // an edge or a software set wins over a clear in the same cycle
  for (g = 0; g < NUM_LINES; g++) begin : g_pend
    always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
        pend_ff[g] <= RST_WORD[g];
      end else if (hit[g] || sw_set[g]) begin
        pend_ff[g] <= 1'b1;
      end else if (pend_clr[g]) begin
        pend_ff[g] <= 1'b0;
      end
    end

    always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
        swtrig_ff[g] <= RST_WORD[g];
      end else if (sw_set[g]) begin
        swtrig_ff[g] <= 1'b1;
      end else if (pend_clr[g]) begin
        swtrig_ff[g] <= 1'b0;
      end
    end
  end

  // a wake pulse needs the line's wake enable and at least one mask bit
  assign wake_hit = |(ev_now & wake_en_ff & (irq_mask_ff | evt_mask_ff));
  assign irq_any  = |(pend_ff & irq_mask_ff);

  // registered outputs
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      IRQ_REQ <= '0;
    end else begin
      IRQ_REQ <= pend_ff & irq_mask_ff;
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      EVT_PULSE <= '0;
    end else begin
      EVT_PULSE <= ev_now & evt_mask_ff;
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      WAKEUP <= 1'b0;
    end else begin
      WAKEUP <= wake_hit;
    end
  end

  // one request line for the core
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      IRQ <= 1'b0;
    end else begin
      IRQ <= irq_any;
    end
  end

  // select words read back from the packed select fields
  always_comb begin
    sel_rd = 32'h0;
    for (int i = 0; i < NUM_EXT; i++) begin
      if (req.addr == `EEL_OFF_SEL0 + 6'(4 * (i / `EEL_SEL_PER_WORD))) begin
        sel_rd[(i % `EEL_SEL_PER_WORD) * `EEL_SEL_FIELD_W +: SEL_W] =
          sel_ff[i*SEL_W +: SEL_W];
      end
    end
  end

  // read mux; unmapped addresses read as zero
  always_comb begin
    rd_mux = 32'h0;
    unique case (req.addr)
      `EEL_OFF_IMR:   rd_mux = irq_mask_ff;
      `EEL_OFF_EMR:   rd_mux = evt_mask_ff;
      `EEL_OFF_RTSR:  rd_mux = trig_ff.rise;
      `EEL_OFF_FTSR:  rd_mux = trig_ff.fall;
      `EEL_OFF_SWIER: rd_mux = swtrig_ff;
      `EEL_OFF_PR:    rd_mux = pend_ff;
      `EEL_OFF_WKEN:  rd_mux = wake_en_ff;
      default:        rd_mux = sel_rd;
    endcase
  end

  // read data stand only in the cycle after the read strobe
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      RDATA <= 32'h0;
    end else if (req.rd) begin
      RDATA <= rd_mux;
    end else begin
      RDATA <= 32'h0;
    end
  end
endmodule : edge_event_line_controller

// File: design/edge_event_params.svh
`ifndef EDGE_EVENT_PARAMS_SVH
`define EDGE_EVENT_PARAMS_SVH
`define EEL_NUM_LINES      32
`define EEL_NUM_EXT        16
`define EEL_NUM_PINS       55
`define EEL_SEL_W          6
`define EEL_ADDR_W         6
`define EEL_OFF_IMR        6'h00
`define EEL_OFF_EMR        6'h04
`define EEL_OFF_RTSR       6'h08
`define EEL_OFF_FTSR       6'h0c
`define EEL_OFF_SWIER      6'h10
`define EEL_OFF_PR         6'h14
`define EEL_OFF_WKEN       6'h18
`define EEL_OFF_SEL0       6'h20
`define EEL_SEL_PER_WORD   4
`define EEL_SEL_FIELD_W    8
`define EEL_RST_WORD       32'h0000_0000
`endif

// File: design/edge_event_pkg.sv
package edge_event_pkg;
  typedef struct packed {
    logic [5:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } reg_req_t;
  typedef struct packed {
    logic [31:0] rise;
    logic [31:0] fall;
  } trig_cfg_t;
endpackage : edge_event_pkg

// File: design/pin_source_mux.sv
// selects for each external line one of the general-purpose pins
module pin_source_mux #(
  parameter int NUM_PINS = 55,
  parameter int NUM_EXT  = 16,
  parameter int SEL_W    = 6
) (
  input  wire logic                     clk,
  input  wire logic                     rst,
  input  wire logic [NUM_PINS-1:0]      pins,
  input  wire logic [NUM_EXT*SEL_W-1:0] sel,
  output logic      [NUM_EXT-1:0]       lines
);
  initial begin
    if (NUM_PINS > (1 << SEL_W)) $error("pin select too narrow");
  end

  genvar g;
  for (g = 0; g < NUM_EXT; g++) begin : g_mux
    logic [SEL_W-1:0] s;
    assign s = sel[g*SEL_W +: SEL_W];
    // left unregistered: a flop here would swallow pulses shorter than a clock
    // period; changing a select may itself look like an edge on that line
    assign lines[g] = (int'(s) < NUM_PINS) ? pins[s] : 1'b0;
  end
endmodule : pin_source_mux

// File: design/pulse_catcher.sv
// catches any pulse on an asynchronous line, even shorter than a clock period, unless ack is clearing the latches,
// by latching it on the line's own edge and handing it to CLK through two flops
module pulse_catcher (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic line_in,
  input  wire logic ack,
  output logic      rise_seen,
  output logic      fall_seen
);
  logic rise_lat;
  logic fall_lat;
  logic clr;
  logic [1:0] rise_sync;
  logic [1:0] fall_sync;

  // ack comes from the clk side once the synchronised flag has been consumed;
  // reset clears the latches too, so no unknown reaches the synchroniser
  assign clr = rst | ack;

  always_ff @(posedge line_in or posedge clr) begin
    if (clr) begin
      rise_lat <= 1'b0;
    end else begin
      rise_lat <= 1'b1;
    end
  end

  always_ff @(negedge line_in or posedge clr) begin
    if (clr) begin
      fall_lat <= 1'b0;
    end else begin
      fall_lat <= 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rise_sync <= 2'h0;
      fall_sync <= 2'h0;
    end else begin
      rise_sync <= {rise_sync[0], rise_lat};
      fall_sync <= {fall_sync[0], fall_lat};
    end
  end

  assign rise_seen = rise_sync[1];
  assign fall_seen = fall_sync[1];
endmodule : pulse_catcher

// File: test/edge_event_line_controller_tb.sv
module edge_event_line_controller_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk, rst, wr, rd, wakeup, irq;
  logic [5:0]  addr;
  logic [31:0] wdata, rdata, irq_req, evt_pulse, src;
  logic [54:0] pins;
  int          n_errors, num_checks, cyc, k, p, m;
  logic        saw_wake, saw_evt;
  edge_event_line_controller dut_u (.CLK(clk), .RST(rst), .PIN_IN(pins), .INT_SRC_IN(src),
    .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .IRQ_REQ(irq_req),
    .EVT_PULSE(evt_pulse), .WAKEUP(wakeup), .IRQ(irq));
  pin_driver pin_u (.pins(pins));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic give_verdict();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : give_verdict
  task automatic wrb(input logic [5:0] a, input logic [31:0] d);
    @(posedge clk) begin addr <= a; wdata <= d; wr <= 1'b1; end
    @(posedge clk) wr <= 1'b0;
  endtask : wrb
  task automatic rdb(input logic [5:0] a, input logic [31:0] exp);
    @(posedge clk) begin addr <= a; rd <= 1'b1; end
    @(posedge clk) rd <= 1'b0;
    #1 chk(rdata, exp);
  endtask : rdb
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (wakeup === 1'b1) saw_wake <= 1'b1;
    if (|evt_pulse === 1'b1) saw_evt <= 1'b1;
    if (cyc == 5000) begin
      n_errors++;
      give_verdict();
    end
  end
  initial begin
    {rst, wr, rd, addr, wdata, src} = {1'b1, 72'h0};
    void'($urandom(32'h35cd));
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    for (k = 0; k < 9; k++) rdb(6'(4 * k), 32'h0);
    for (k = 0; k < 7; k++) if (k != 4 && k != 5) begin
      p = $urandom;
      wrb(6'(4 * k), p);
      rdb(6'(4 * k), p);
    end
    wrb(6'h00, 32'hffff_ffff);
    k = $urandom_range(31, 0);
    wrb(6'h10, 32'h1 << k);
    repeat (10) @(posedge clk);
    rdb(6'h14, 32'h1 << k);
    chk(irq_req, 32'h1 << k);
    chk({31'h0, irq}, 32'h1);
    wrb(6'h00, 32'h0);
    repeat (4) @(posedge clk);
    #1 chk(irq_req, 32'h0);
    rdb(6'h14, 32'h1 << k);
    wrb(6'h14, 32'h1 << k);
    rdb(6'h14, 32'h0);
    {k, p} = {$urandom_range(15, 0), $urandom_range(54, 0)};
    wrb(6'h20 + 6'(4 * (k / 4)), 32'(p) << (8 * (k % 4)));
    for (m = 0; m < 3; m++) begin
      wrb(6'h08, 32'(m != 1) << k);
      wrb(6'h0c, 32'(m != 0) << k);
      pin_u.level(p, 1'b1);
      repeat (10) @(posedge clk);
      rdb(6'h14, 32'(m != 1) << k);
      wrb(6'h14, 32'hffff_ffff);
      pin_u.level(p, 1'b0);
      repeat (10) @(posedge clk);
      rdb(6'h14, 32'(m != 0) << k);
      wrb(6'h14, 32'hffff_ffff);
    end
    wrb(6'h0c, 32'h0);
    wrb(6'h04, 32'h1 << k);
    wrb(6'h18, 32'h1 << k);
    {saw_wake, saw_evt} = 2'b00;
    pin_u.pulse(p, 20);
    repeat (10) @(posedge clk);
    rdb(6'h14, 32'h1 << k);
    chk({31'h0, saw_wake}, 32'h1);
    chk({31'h0, saw_evt}, 32'h1);
    chk(irq_req, 32'h0);
    wrb(6'h14, 32'hffff_ffff);
    m = $urandom_range(31, 16);
    wrb(6'h08, 32'h1 << m);
    @(posedge clk) src <= 32'h1 << m;
    repeat (10) @(posedge clk);
    rdb(6'h14, 32'h1 << m);
    wrb(6'h04, 32'h0);
    wrb(6'h14, 32'hffff_ffff);
    rdb(6'h14, 32'h0);
    give_verdict();
  end
endmodule : edge_event_line_controller_tb

// File: test/edge_event_monitor.sv
module edge_event_monitor #(
  parameter int NUM_LINES = 32
) (
  input wire logic                 CLK,
  input wire logic                 RST,
  input wire logic [5:0]           ADDR,
  input wire logic [31:0]          WDATA,
  input wire logic                 WR,
  input wire logic                 RD,
  input wire logic [31:0]          RDATA,
  input wire logic [NUM_LINES-1:0] IRQ_REQ,
  input wire logic [NUM_LINES-1:0] EVT_PULSE,
  input wire logic                 WAKEUP,
  input wire logic                 IRQ
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);
  sequence s_irq_off; WR && ADDR == 6'h00 && WDATA == 32'h0; endsequence
  sequence s_evt_off; WR && ADDR == 6'h04 && WDATA == 32'h0; endsequence
  property p_irq_or; IRQ == |IRQ_REQ; endproperty
  property p_req_hold; (|($past(IRQ_REQ) & ~IRQ_REQ)) |-> $past(WR) || $past(WR, 2); endproperty
  property p_irq_off; s_irq_off |-> ##2 IRQ_REQ == '0; endproperty
  property p_evt_off; s_evt_off |-> ##2 (EVT_PULSE == '0) [*3]; endproperty
  property p_rd_idle; !$past(RD) |-> RDATA == 32'h0; endproperty
  property p_rd_hole; RD && ADDR == 6'h1c |=> RDATA == 32'h0; endproperty
  property p_evt_one; (EVT_PULSE & $past(EVT_PULSE)) == '0; endproperty
  property p_wake_one; WAKEUP |=> !WAKEUP; endproperty
  a_irq_or: assert property (p_irq_or) else $error("irq not or of requests");
  a_req_hold: assert property (p_req_hold) else $error("request dropped unasked");
  a_irq_off: assert property (p_irq_off) else $error("masked request seen");
  a_evt_off: assert property (p_evt_off) else $error("masked event seen");
  a_rd_idle: assert property (p_rd_idle) else $error("read data without read");
  a_rd_hole: assert property (p_rd_hole) else $error("unmapped read not zero");
  a_evt_one: assert property (p_evt_one) else $error("event longer than one cycle");
  a_wake_one: assert property (p_wake_one) else $error("wake longer than one cycle");
endmodule : edge_event_monitor
bind edge_event_line_controller edge_event_monitor #(.NUM_LINES(NUM_LINES)) mon_u (
  .CLK(CLK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
  .IRQ_REQ(IRQ_REQ), .EVT_PULSE(EVT_PULSE), .WAKEUP(WAKEUP), .IRQ(IRQ));

// File: test/pin_driver.sv
// stands for the pins: levels and pulses come at any time, not tied to the clock
module pin_driver #(
  parameter int NUM_PINS = 55
) (
  output logic [NUM_PINS-1:0] pins
);
  timeunit 1ns;
  timeprecision 1ns;
  initial pins = '0;
  task automatic pulse(input int idx, input int width);
    pins[idx] = ~pins[idx];
    #(width) pins[idx] = ~pins[idx];
  endtask : pulse
  task automatic level(input int idx, input logic v);
    pins[idx] = v;
  endtask : level
endmodule : pin_driver
